// [bench/iom_chk_monitor.sv]
// Concurrent checks on the monitor bus answer
`default_nettype none
module iom_chk_monitor
  import iom_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic mon_rd_n,
  input wire logic mon_wr_n,
  input wire logic mon_data_oe,
  input wire logic mon_ack_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_held;
    (!mon_rd_n || !mon_wr_n) [*8];
  endsequence
  sequence s_idle;
    (mon_rd_n && mon_wr_n) [*8];
  endsequence
  a_ack_on_strobe: assert property (s_held |-> !mon_ack_n)
    else $error("monitor ack missing under strobe");
  a_ack_drops: assert property (s_idle |-> mon_ack_n)
    else $error("monitor ack outside cycle");
  a_ack_no_stretch: assert property ($rose(mon_rd_n && mon_wr_n) |-> ##[1:6] mon_ack_n)
    else $error("monitor cycle stretched");
  a_ack_holds: assert property (!mon_ack_n && !(mon_rd_n && mon_wr_n) |=> !mon_ack_n)
    else $error("monitor ack dropped early");
  a_oe_with_ack: assert property (mon_data_oe |-> !mon_ack_n)
    else $error("monitor data driven without ack");
  a_oe_read_only: assert property (mon_rd_n [*8] |-> !mon_data_oe)
    else $error("monitor data driven without read");
  a_oe_after_read: assert property ($rose(mon_data_oe) |-> !mon_rd_n && !$past(mon_rd_n, 3))
    else $error("monitor data driven too soon");
  a_reset_quiet: assert property ($rose(rst_n) |-> mon_ack_n && !mon_data_oe)
    else $error("monitor outputs active after reset");
endmodule : iom_chk_monitor
bind iom_monitor iom_chk_monitor u_chk (.mclk(mclk), .rst_n(rst_n), .mon_rd_n(mon_rd_n),
  .mon_wr_n(mon_wr_n), .mon_data_oe(mon_data_oe), .mon_ack_n(mon_ack_n));
`default_nettype wire

// [bench/iom_ctl_bus.sv]
// Control bus master and point card model feeding the snoop port
`default_nettype none
module iom_ctl_bus (
  input wire logic mclk,
  output logic [8:0] ctl_addr,
  output logic [7:0] ctl_data,
  output logic ctl_rd_n,
  output logic ctl_wr_n,
  output logic ctl_ack_n,
  output logic ctl_word
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ctl_addr = 9'h000;
    ctl_data = 8'hFF;
    ctl_rd_n = 1'b1;
    ctl_wr_n = 1'b1;
    ctl_ack_n = 1'b1;
    ctl_word = 1'b0;
  end
  task automatic xfer(input logic rd, input logic [8:0] a, input logic [7:0] d,
                      input logic ack, input logic word);
    @(posedge mclk);
    ctl_addr <= a;
    ctl_data <= d;
    ctl_word <= word;
    ctl_rd_n <= !rd;
    ctl_wr_n <= rd;
    repeat (2) @(posedge mclk);
    ctl_ack_n <= !ack;
    repeat (4) @(posedge mclk);
    ctl_rd_n <= 1'b1;
    ctl_wr_n <= 1'b1;
    ctl_ack_n <= 1'b1;
    // Held past the strobe: the snoop sees the strobe late
    repeat (5) @(posedge mclk);
    ctl_data <= ~d;
    ctl_addr <= ~a;
    ctl_word <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask : xfer
endmodule : iom_ctl_bus
`default_nettype wire

// [bench/tb.sv]
// Self-checking bench for the bus monitor shared RAM
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_n, clk_en, ack_bypass, ctl_rd_n, ctl_wr_n, ctl_ack_n, ctl_word;
  logic mon_rd_n, mon_wr_n, mon_data_oe, mon_ack_n;
  logic [8:0] ctl_addr, mon_addr;
  logic [7:0] ctl_data, mon_data_o;
  int error_cnt, check_count, cyc;
  iom_ctl_bus u_ctl (.mclk(mclk), .ctl_addr(ctl_addr), .ctl_data(ctl_data),
    .ctl_rd_n(ctl_rd_n), .ctl_wr_n(ctl_wr_n), .ctl_ack_n(ctl_ack_n), .ctl_word(ctl_word));
  iom_monitor u_iom_monitor (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .ctl_addr(ctl_addr),
    .ctl_data(ctl_data), .ctl_rd_n(ctl_rd_n), .ctl_wr_n(ctl_wr_n), .ctl_ack_n(ctl_ack_n),
    .ctl_word(ctl_word), .ack_bypass(ack_bypass), .mon_addr(mon_addr), .mon_rd_n(mon_rd_n),
    .mon_wr_n(mon_wr_n), .mon_data_o(mon_data_o), .mon_data_oe(mon_data_oe),
    .mon_ack_n(mon_ack_n));
  task automatic chk(input string name, input iom_pkg::iom_byte_t seen, exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  // One monitor cycle; a write waits for the ack, a read for driven data
  task automatic mcyc(input logic wr, input logic [8:0] a, output iom_pkg::iom_byte_t v);
    int n;
    n = 0;
    @(posedge mclk);
    mon_addr <= a;
    mon_rd_n <= wr;
    mon_wr_n <= !wr;
    do begin
      @(posedge mclk);
      n++;
    end while (!(wr ? mon_ack_n === 1'b0 : mon_data_oe === 1'b1) && n < 20);
    v = mon_data_o;
    chk("mon_ack", {7'h00, mon_ack_n}, 8'h00);
    chk("mon_oe", {7'h00, mon_data_oe}, {7'h00, !wr});
    mon_rd_n <= 1'b1;
    mon_wr_n <= 1'b1;
    mon_addr <= ~a;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (mon_ack_n !== 1'b1 && n < 20);
    chk("mon_release", {6'h00, mon_ack_n, mon_data_oe}, 8'h02);
    repeat (4) @(posedge mclk);
  endtask : mcyc
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_snoop;
    iom_pkg::iom_byte_t v;
    u_ctl.xfer(0, 9'h1FF, 8'hC3, 0, 0);
    u_ctl.xfer(0, 9'h000, 8'h5A, 0, 0);
    mcyc(0, 9'h1FF, v);
    chk("top", v, 8'hC3);
    mcyc(0, 9'h000, v);
    chk("bottom", v, 8'h5A);
    u_ctl.xfer(1, 9'h055, 8'hA5, 1, 0);
    u_ctl.xfer(1, 9'h055, 8'h3C, 0, 0);
    mcyc(0, 9'h055, v);
    chk("rd_ack", v, 8'hA5);
    ack_bypass <= 1'b1;
    u_ctl.xfer(1, 9'h055, 8'h3C, 0, 0);
    mcyc(0, 9'h055, v);
    chk("bypass", v, 8'h3C);
    ack_bypass <= 1'b0;
    mcyc(1, 9'h1FF, v);
    mcyc(0, 9'h1FF, v);
    chk("mon_wr", v, 8'hC3);
    $display("test snoop done");
  endtask : t_snoop
  task automatic t_word;
    iom_pkg::iom_byte_t v;
    u_ctl.xfer(0, 9'h100, 8'hEE, 0, 0);
    u_ctl.xfer(0, 9'h100, 8'h11, 0, 1);
    mcyc(0, 9'h100, v);
    chk("held_low", v, 8'hEE);
    u_ctl.xfer(0, 9'h101, 8'h22, 0, 1);
    mcyc(0, 9'h100, v);
    chk("word_low", v, 8'h11);
    mcyc(0, 9'h101, v);
    chk("word_high", v, 8'h22);
    u_ctl.xfer(0, 9'h0AA, 8'h66, 0, 0);
    // Read is timed so its RAM fetch lands in the same cycle as the write
    fork
      u_ctl.xfer(0, 9'h0AA, 8'h77, 0, 0);
      begin
        repeat (6) @(posedge mclk);
        mcyc(0, 9'h0AA, v);
      end
    join
    chk("collide", v, (v === 8'h77) ? 8'h77 : 8'h66);
    mcyc(0, 9'h0AA, v);
    chk("after", v, 8'h77);
    $display("test word done");
  endtask : t_word
  task automatic t_hold;
    iom_pkg::iom_byte_t v;
    u_ctl.xfer(0, 9'h033, 8'h12, 0, 0);
    clk_en <= 1'b0;
    u_ctl.xfer(0, 9'h033, 8'h34, 0, 0);
    clk_en <= 1'b1;
    mcyc(0, 9'h033, v);
    chk("frozen", v, 8'h12);
    $display("test hold done");
  endtask : t_hold
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    ack_bypass = 1'b0;
    mon_addr = 9'h000;
    mon_rd_n = 1'b1;
    mon_wr_n = 1'b1;
    error_cnt = 0;
    check_count = 0;
    cyc = 0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    t_snoop();
    t_word();
    t_hold();
    give_verdict();
  end
endmodule : tb
`default_nettype wire

// [design/iom_dpram.sv]
// Shared 512-byte RAM: one control-side write port, one monitor-side read port
`default_nettype none
`include "iom_regs.svh"
module iom_dpram
  import iom_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  iom_ram_if.ram port
);
  iom_byte_t mem [`IOM_RAM_DEPTH];

  always_ff @(posedge mclk) begin
    if (port.ce && port.we) begin
      mem[port.waddr] <= port.wdata;
    end
  end

  // Same-byte collision hands back the whole new byte, never a mix
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      port.rdata <= `IOM_DATA_RST;
    end else if (port.ce && port.re) begin
      if (port.we && port.waddr == port.raddr) begin
        port.rdata <= port.wdata;
      end else begin
        port.rdata <= mem[port.raddr];
      end
    end
  end
endmodule : iom_dpram
`default_nettype wire

// [design/iom_monitor.sv]
// Bus monitor: snoops the control bus into shared RAM, serves the monitor bus
`default_nettype none
`include "iom_regs.svh"
module iom_monitor
  import iom_pkg::*;
#(
  parameter int ADDR_W = `IOM_ADDR_W,
  parameter int DATA_W = `IOM_DATA_W
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] ctl_addr,
  input wire logic [DATA_W-1:0] ctl_data,
  input wire logic ctl_rd_n,
  input wire logic ctl_wr_n,
  input wire logic ctl_ack_n,
  input wire logic ctl_word,
  input wire logic ack_bypass,
  input wire logic [ADDR_W-1:0] mon_addr,
  input wire logic mon_rd_n,
  input wire logic mon_wr_n,
  output logic [DATA_W-1:0] mon_data_o,
  output logic mon_data_oe,
  output logic mon_ack_n
);
  if (ADDR_W != `IOM_ADDR_W || DATA_W != `IOM_DATA_W) begin : g_bad_width
    $error("iom_monitor: RAM is fixed at 512 bytes of 8 bits");
  end

  localparam int CW = ADDR_W + DATA_W + 5;
  localparam int MW = ADDR_W + 2;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [CW-1:0] c_s1_q, c_s2_q, c_s3_q, c_v_q;
  logic [MW-1:0] m_s1_q, m_s2_q, m_s3_q, m_v_q;

  // A bit moves only once stages two and three agree
  function automatic logic [CW-1:0] iom_settle(input logic [CW-1:0] a,
                                              input logic [CW-1:0] b,
                                              input logic [CW-1:0] prev);
    iom_settle = (a & ~(a ^ b)) | (prev & (a ^ b));
  endfunction : iom_settle

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      c_s1_q <= '1;
      c_s2_q <= '1;
      c_s3_q <= '1;
      c_v_q <= '1;
    end else if (clk_en) begin
      c_s1_q <= {ctl_rd_n, ctl_wr_n, ctl_ack_n, ctl_word, ack_bypass, ctl_addr, ctl_data};
      c_s2_q <= c_s1_q;
      c_s3_q <= c_s2_q;
      c_v_q <= iom_settle(c_s2_q, c_s3_q, c_v_q);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      m_s1_q <= '1;
      m_s2_q <= '1;
      m_s3_q <= '1;
      m_v_q <= '1;
    end else if (clk_en) begin
      m_s1_q <= {mon_rd_n, mon_wr_n, mon_addr};
      m_s2_q <= m_s1_q;
      m_s3_q <= m_s2_q;
      m_v_q <= MW'(iom_settle(CW'(m_s2_q), CW'(m_s3_q), CW'(m_v_q)));
    end
  end

  logic c_rd, c_wr, c_ack, c_word, c_bypass;
  iom_addr_t c_addr;
  iom_byte_t c_data;
  logic m_rd, m_wr;
  iom_addr_t m_addr;

  // Control data pins are only ever sampled, no driver exists for them
  assign c_rd = ~c_v_q[CW-1];
  assign c_wr = ~c_v_q[CW-2];
  assign c_ack = ~c_v_q[CW-3];
  assign c_word = c_v_q[CW-4];
  assign c_bypass = c_v_q[CW-5];
  assign c_addr = c_v_q[ADDR_W+DATA_W-1:DATA_W];
  assign c_data = c_v_q[DATA_W-1:0];
  assign m_rd = ~m_v_q[MW-1];
  assign m_wr = ~m_v_q[MW-2];
  assign m_addr = m_v_q[ADDR_W-1:0];

  // ------------------------------------------------------------
  // Control bus snoop
  // ------------------------------------------------------------
  iom_ram_if ram_if ();
  iom_ctl_e cs_q;
  logic is_wr_q, ack_seen_q, word_q;
  iom_addr_t addr_q, pend_addr_q;
  iom_byte_t data_q, pend_data_q;
  logic pend_v_q;
  logic store, hold_low;
  logic we_q;
  iom_addr_t waddr_q;
  iom_byte_t wdata_q;

  assign store = is_wr_q || ack_seen_q || c_bypass;
  assign hold_low = word_q && !addr_q[`IOM_HIGH_BYTE_BIT];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cs_q <= IOM_CS_IDLE;
      is_wr_q <= 1'b0;
      ack_seen_q <= 1'b0;
      word_q <= 1'b0;
      addr_q <= '0;
      data_q <= `IOM_DATA_RST;
    end else if (clk_en) begin
      unique case (cs_q)
        IOM_CS_IDLE: begin
          if (c_rd || c_wr) begin
            cs_q <= IOM_CS_CYCLE;
            is_wr_q <= c_wr;
            ack_seen_q <= c_ack;
          end
        end
        IOM_CS_CYCLE: begin
          if (c_rd || c_wr) begin
            // Latest values win; the bus settles before the strobe ends
            addr_q <= c_addr;
            data_q <= c_data;
            word_q <= c_word;
            ack_seen_q <= ack_seen_q | c_ack;
          end else if (store && !hold_low && pend_v_q) begin
            cs_q <= IOM_CS_STORE_LOW;
          end else begin
            cs_q <= IOM_CS_IDLE;
          end
        end
        IOM_CS_STORE_LOW: begin
          cs_q <= IOM_CS_IDLE;
        end
      endcase
    end
  end

  // Low byte of a word waits here; RAM keeps the whole old word meanwhile
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pend_v_q <= 1'b0;
      pend_addr_q <= '0;
      pend_data_q <= `IOM_DATA_RST;
    end else if (clk_en) begin
      if (cs_q == IOM_CS_CYCLE && !c_rd && !c_wr && store && hold_low) begin
        pend_v_q <= 1'b1;
        pend_addr_q <= addr_q;
        pend_data_q <= data_q;
      end else if (cs_q == IOM_CS_STORE_LOW) begin
        pend_v_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      we_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= `IOM_DATA_RST;
    end else if (clk_en) begin
      we_q <= 1'b0;
      if (cs_q == IOM_CS_CYCLE && !c_rd && !c_wr && store && !hold_low) begin
        we_q <= 1'b1;
        waddr_q <= addr_q;
        wdata_q <= data_q;
      end else if (cs_q == IOM_CS_STORE_LOW) begin
        we_q <= 1'b1;
        waddr_q <= pend_addr_q;
        wdata_q <= pend_data_q;
      end
    end
  end

  // ------------------------------------------------------------
  // Monitor bus read port
  // ------------------------------------------------------------
  logic lock;
  logic rd_done_q, re_q, rvalid_q;
  iom_addr_t raddr_q;

  // Between the high and the low byte commit the word is torn; reads wait
  assign lock = (cs_q == IOM_CS_STORE_LOW) || (we_q && pend_v_q);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_done_q <= 1'b0;
      re_q <= 1'b0;
      rvalid_q <= 1'b0;
      raddr_q <= '0;
    end else if (clk_en) begin
      re_q <= 1'b0;
      rvalid_q <= re_q;
      if (!m_rd) begin
        rd_done_q <= 1'b0;
      end else if (!rd_done_q && !re_q && !lock) begin
        re_q <= 1'b1;
        raddr_q <= m_addr;
        rd_done_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mon_data_o <= `IOM_DATA_RST;
      mon_data_oe <= 1'b0;
      mon_ack_n <= 1'b1;
    end else if (clk_en) begin
      // Writes get an acknowledge but never reach the RAM
      mon_ack_n <= ~(m_rd || m_wr);
      if (!m_rd) begin
        mon_data_oe <= 1'b0;
      end else if (rvalid_q) begin
        mon_data_o <= ram_if.rdata;
        mon_data_oe <= 1'b1;
      end
    end
  end

  assign ram_if.ce = clk_en;
  assign ram_if.we = we_q;
  assign ram_if.waddr = waddr_q;
  assign ram_if.wdata = wdata_q;
  assign ram_if.re = re_q;
  assign ram_if.raddr = raddr_q;

  iom_dpram u_ram (
    .mclk(mclk),
    .rst_n(rst_n),
    .port(ram_if.ram)
  );
endmodule : iom_monitor
`default_nettype wire

// [design/iom_pkg.sv]
// Types shared by the bus monitor shared RAM modules
`default_nettype none
`include "iom_regs.svh"
package iom_pkg;
  typedef logic [`IOM_ADDR_W-1:0] iom_addr_t;
  typedef logic [`IOM_DATA_W-1:0] iom_byte_t;
  typedef enum logic [1:0] {
    IOM_CS_IDLE,
    IOM_CS_CYCLE,
    IOM_CS_STORE_LOW
  } iom_ctl_e;
endpackage : iom_pkg
`default_nettype wire

// [design/iom_ram_if.sv]
// Carrier between the monitor control logic and the shared RAM
`default_nettype none
interface iom_ram_if;
  import iom_pkg::*;
  logic ce;
  logic we;
  iom_addr_t waddr;
  iom_byte_t wdata;
  logic re;
  iom_addr_t raddr;
  iom_byte_t rdata;
  modport ctrl (output ce, output we, output waddr, output wdata, output re, output raddr,
    input rdata);
  modport ram (input ce, input we, input waddr, input wdata, input re, input raddr,
    output rdata);
endinterface : iom_ram_if
`default_nettype wire

// [design/iom_regs.svh]
// Constants for the bus monitor shared RAM: widths and synchroniser depth
`ifndef IOM_REGS_SVH
`define IOM_REGS_SVH
`define IOM_ADDR_W 9
`define IOM_DATA_W 8
`define IOM_RAM_DEPTH 512
`define IOM_SYNC_STAGES 3
`define IOM_HIGH_BYTE_BIT 0
`define IOM_DATA_RST 8'h00
`endif
